/* File: verilog/scp_pkg.sv */
// Shared constants of the serial configuration port, both ends.
// Assumes a 40 MHz system clock on each end.
package scp_pkg;
   // Instruction word layout.
   localparam int         INSTR_BITS   = 16;
   localparam int         INSTR_RW_BIT = 15;
   localparam int         LEN_MSB      = 14;
   localparam int         LEN_LSB      = 13;
   localparam int         ADDR_MSB     = 9;
   localparam logic [1:0] LEN_STREAM   = 2'h3;
   // Device register space.
   localparam logic [9:0] ADDR_PORT_CFG = 10'h000;
   localparam logic [9:0] ADDR_READBACK = 10'h004;
   localparam logic [9:0] ADDR_UPDATE   = 10'h232;
   localparam logic [9:0] ADDR_LAST     = 10'h232;
   localparam int         REG_COUNT     = 32'h0000_0233;
   localparam int         CFG_UNIDIR_BIT    = 0;
   localparam int         CFG_LSB_FIRST_BIT = 1;
   localparam logic [7:0] CFG_RESET_VALUE   = 8'h18;
   localparam int         READBACK_ACT_BIT  = 0;
   localparam int         UPDATE_BIT        = 0;
   // Controller registers on APB.
   localparam logic [7:0] HREG_CTRL   = 8'h00;
   localparam logic [7:0] HREG_INSTR  = 8'h04;
   localparam logic [7:0] HREG_WDATA  = 8'h08;
   localparam logic [7:0] HREG_RDATA  = 8'h0C;
   localparam logic [7:0] HREG_STATUS = 8'h10;
   localparam int         CTRL_START_BIT  = 0;
   localparam int         CTRL_LSB_BIT    = 1;
   localparam int         CTRL_UNIDIR_BIT = 2;
   localparam int         CTRL_STALL_BIT  = 3;
   localparam int         STREAM_BYTES    = 4;
   // Link timing.
   localparam int         CLOCK_NS      = 25;
   localparam int         SCLK_NS       = 200;
   localparam int         SCLK_HALF     = SCLK_NS / (2 * CLOCK_NS);
   localparam int         STALL_NS      = 400;
   localparam int         STALL_CYCLES  = STALL_NS / CLOCK_NS;
endpackage

/* File: verilog/scp_if.sv */
// Serial link between the controller end and the configuration port.
// Resolves the shared data pin from both enables; undriven reads low.
`timescale 1ns/1ps
interface scp_if;
   logic cs_n;
   logic sclk;
   logic host_sdio_out;
   logic host_sdio_oe;
   logic dev_sdio_out;
   logic dev_sdio_oe;
   logic separate_readback_pin_out;
   logic separate_readback_pin_oe;
   logic sdio;
   logic separate_readback_pin;

   assign sdio = dev_sdio_oe ? dev_sdio_out :
                 (host_sdio_oe & host_sdio_out);
   assign separate_readback_pin = separate_readback_pin_oe &
                                  separate_readback_pin_out;

   modport device (
      input  cs_n, sclk, sdio,
      output dev_sdio_out, dev_sdio_oe,
      output separate_readback_pin_out, separate_readback_pin_oe
   );
   modport host (
      output cs_n, sclk, host_sdio_out, host_sdio_oe,
      input  sdio, separate_readback_pin
   );
endinterface

/* File: verilog/scp_device.sv */
// Configuration port slave: shadow and active register banks.
// Assumes the link pins are asynchronous to clock and that sclk is
// far slower than clock (at least four clock periods per phase).
//
// The implementer's own choices: the register addresses and the active register readout port.
`timescale 1ns/1ps
module scp_device (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset_n,
   // Serial link
   scp_if.device           link,
   // Active register readout
   input  wire logic [9:0] user_addr,
   output logic      [7:0] user_data,
   output logic            update_pulse,
   output logic            unidir_mode,
   output logic            lsb_first
);
   typedef enum logic [2:0] {
      SCP_IDLE, SCP_INSTR, SCP_DATA, SCP_STALL, SCP_DONE
   } scp_dev_state_t;

   scp_dev_state_t state;
   logic [2:0]  cs_sync;
   logic [2:0]  sclk_sync;
   logic [1:0]  sdio_sync;
   logic [2:0]  bit_cnt;
   logic        instr_hi;
   logic [15:0] instr;
   logic [7:0]  rx_byte;
   logic [7:0]  tx;
   logic [9:0]  addr;
   logic        is_read;
   logic        stream;
   logic [1:0]  bytes_left;
   logic        resume_data;
   logic        bit_out;
   logic        drive;
   logic        drive_sep;
   logic [7:0]  port_cfg;
   logic        readback_active;
   logic        wr_en;
   logic [9:0]  wr_addr;
   logic [7:0]  wr_data;
   logic [7:0]  shadow [0:scp_pkg::REG_COUNT-1];
   logic [7:0]  active [0:scp_pkg::REG_COUNT-1];

   logic        cs_high;
   logic        cs_rise;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        din;
   logic        lsb;
   logic        byte_end;
   logic [15:0] next_instr;
   logic [7:0]  next_rx;
   logic [9:0]  next_addr;
   logic [9:0]  start_addr;

   // Only the second and third stages feed logic.
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         cs_sync   <= 3'h7;
         sclk_sync <= 3'h0;
         sdio_sync <= 2'h0;
      end
      else
      begin
         cs_sync   <= {cs_sync[1:0], link.cs_n};
         sclk_sync <= {sclk_sync[1:0], link.sclk};
         sdio_sync <= {sdio_sync[0], link.sdio};
      end
   end

   assign cs_high   = cs_sync[1];
   assign cs_rise   = cs_sync[1] & ~cs_sync[2];
   assign sclk_rise = sclk_sync[1] & ~sclk_sync[2] & ~cs_high;
   assign sclk_fall = ~sclk_sync[1] & sclk_sync[2] & ~cs_high;
   assign din       = sdio_sync[1];
   assign lsb       = port_cfg[scp_pkg::CFG_LSB_FIRST_BIT];
   assign byte_end  = sclk_rise && (bit_cnt == 3'h7);
   assign next_instr = lsb ? {din, instr[15:1]} : {instr[14:0], din};
   assign next_rx    = lsb ? {din, rx_byte[7:1]} : {rx_byte[6:0], din};
   assign start_addr = next_instr[scp_pkg::ADDR_MSB:0];

   // The address wraps 0x000 to 0x232 going down, 0x232 to 0 going up.
   always_comb
   begin
      if (lsb)
         next_addr = (addr == scp_pkg::ADDR_LAST) ? 10'h000 :
                     10'(addr + 10'h001);
      else
         next_addr = (addr == 10'h000) ? scp_pkg::ADDR_LAST :
                     10'(addr - 10'h001);
   end

   // Readback byte, already turned into wire order.
   function automatic logic [7:0] read_byte(input logic [9:0] a);
      logic [7:0] v;
      logic [7:0] w;
      v = 8'h00;
      if (a == scp_pkg::ADDR_PORT_CFG)
         v = port_cfg;
      else if (a == scp_pkg::ADDR_READBACK)
         v = {7'h00, readback_active};
      else if (a <= scp_pkg::ADDR_LAST)
         v = readback_active ? active[a] : shadow[a];
      for (int i = 0; i < 8; i++)
         w[i] = v[7 - i];
      return lsb ? w : v;
   endfunction

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         state           <= SCP_IDLE;
         bit_cnt         <= 3'h0;
         instr_hi        <= 1'b0;
         instr           <= 16'h0000;
         rx_byte         <= 8'h00;
         tx              <= 8'h00;
         addr            <= 10'h000;
         is_read         <= 1'b0;
         stream          <= 1'b0;
         bytes_left      <= 2'h0;
         resume_data     <= 1'b0;
         bit_out         <= 1'b0;
         port_cfg        <= scp_pkg::CFG_RESET_VALUE;
         readback_active <= 1'b0;
         wr_en           <= 1'b0;
         wr_addr         <= 10'h000;
         wr_data         <= 8'h00;
      end
      else
      begin
         wr_en <= 1'b0;
         if (cs_rise && state != SCP_IDLE)
         begin
            if (bit_cnt != 3'h0)
               state <= SCP_IDLE;
            else if (state == SCP_DONE || (state == SCP_DATA && stream))
               state <= SCP_IDLE;
            else if (state == SCP_INSTR || state == SCP_DATA)
            begin
               resume_data <= (state == SCP_DATA);
               state       <= SCP_STALL;
               // The host lowers sclk as it raises select, so the
               // first bit of the next byte is launched here.
               if (state == SCP_DATA && is_read &&
                   sclk_sync[2] && !sclk_sync[1])
               begin
                  bit_out <= tx[7];
                  tx      <= {tx[6:0], 1'b0};
               end
            end
            bit_cnt <= 3'h0;
         end
         else
         begin
            case (state)
               SCP_IDLE:
                  if (!cs_high)
                  begin
                     state    <= SCP_INSTR;
                     bit_cnt  <= 3'h0;
                     resume_data <= 1'b0;
                     instr_hi <= 1'b0;
                  end
               SCP_STALL:
                  if (!cs_high)
                     state <= resume_data ? SCP_DATA : SCP_INSTR;
               SCP_INSTR:
                  if (sclk_rise)
                  begin
                     instr   <= next_instr;
                     bit_cnt <= 3'(bit_cnt + 3'h1);
                     if (byte_end)
                     begin
                        instr_hi <= 1'b1;
                        if (instr_hi)
                        begin
                           state   <= SCP_DATA;
                           is_read <= next_instr[scp_pkg::INSTR_RW_BIT];
                           stream  <= next_instr[scp_pkg::LEN_MSB:
                                                 scp_pkg::LEN_LSB]
                                      == scp_pkg::LEN_STREAM;
                           bytes_left <= next_instr[scp_pkg::LEN_MSB:
                                                    scp_pkg::LEN_LSB];
                           addr <= start_addr;
                           tx   <= read_byte(start_addr);
                        end
                     end
                  end
               SCP_DATA:
               begin
                  if (sclk_rise)
                  begin
                     rx_byte <= next_rx;
                     bit_cnt <= 3'(bit_cnt + 3'h1);
                  end
                  if (sclk_fall && is_read)
                  begin
                     bit_out <= tx[7];
                     tx      <= {tx[6:0], 1'b0};
                  end
                  if (byte_end)
                  begin
                     if (!is_read && addr <= scp_pkg::ADDR_LAST)
                     begin
                        wr_en   <= 1'b1;
                        wr_addr <= addr;
                        wr_data <= next_rx;
                     end
                     if (!is_read && addr == scp_pkg::ADDR_PORT_CFG)
                        port_cfg <= next_rx;
                     if (!is_read && addr == scp_pkg::ADDR_READBACK)
                        readback_active <=
                           next_rx[scp_pkg::READBACK_ACT_BIT];
                     addr <= next_addr;
                     tx   <= read_byte(next_addr);
                     if (stream)
                     begin
                        if (addr == scp_pkg::ADDR_LAST)
                           state <= SCP_DONE;
                     end
                     else if (bytes_left == 2'h0)
                        state <= SCP_DONE;
                     else
                        bytes_left <= 2'(bytes_left - 2'h1);
                  end
               end
               SCP_DONE:
                  if (sclk_fall && is_read)
                  begin
                     bit_out <= tx[7];
                     tx      <= {tx[6:0], 1'b0};
                  end
               default:
                  state <= SCP_IDLE;
            endcase
         end
      end
   end

   // The pin is claimed only from the first falling edge after the
   // instruction, so the host's last instruction bit never collides.
   // After a stall in the data phase a bit is already waiting, so the
   // pin is claimed again as soon as select falls.
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         drive     <= 1'b0;
         drive_sep <= 1'b0;
      end
      else if (cs_high || !is_read ||
               !(state == SCP_DATA || state == SCP_DONE))
      begin
         drive     <= 1'b0;
         drive_sep <= 1'b0;
      end
      else if (sclk_fall || resume_data)
      begin
         drive     <= ~port_cfg[scp_pkg::CFG_UNIDIR_BIT];
         drive_sep <= port_cfg[scp_pkg::CFG_UNIDIR_BIT];
      end
   end

   assign link.dev_sdio_out = bit_out;
   assign link.dev_sdio_oe = drive;
   assign link.separate_readback_pin_out = bit_out;
   assign link.separate_readback_pin_oe = drive_sep;

   // Banks are storage only and carry no reset.
   always_ff @(posedge clock)
   begin
      if (wr_en)
         shadow[wr_addr] <= (wr_addr == scp_pkg::ADDR_UPDATE) ?
                            {wr_data[7:1], 1'b0} : wr_data;
      if (update_pulse)
         active <= shadow;
      user_data <= (user_addr <= scp_pkg::ADDR_LAST) ?
                   active[user_addr] : 8'h00;
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         update_pulse <= 1'b0;
         unidir_mode  <= 1'b0;
         lsb_first    <= 1'b0;
      end
      else
      begin
         update_pulse <= wr_en && wr_addr == scp_pkg::ADDR_UPDATE &&
                         wr_data[scp_pkg::UPDATE_BIT];
         unidir_mode  <= port_cfg[scp_pkg::CFG_UNIDIR_BIT];
         lsb_first    <= lsb;
      end
   end
endmodule

/* File: verilog/scp_host.sv */
// Controller end: APB slave that runs one serial transaction per start.
// Assumes software keeps bit order and pin mode equal to the device's.
`timescale 1ns/1ps
module scp_host (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        reset_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial link
   scp_if.host              link
);
   typedef enum logic [2:0] {
      SCH_IDLE, SCH_LEAD, SCH_SHIFT, SCH_GAP, SCH_TAIL
   } scp_host_state_t;

   scp_host_state_t state;
   logic [3:0]  ctrl;
   logic [15:0] instr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [31:0] rx;
   logic [47:0] tx;
   logic [5:0]  bit_idx;
   logic [5:0]  nbits;
   logic [4:0]  div;
   logic [1:0]  in_sync;
   logic        cs_n;
   logic        sclk;
   logic        sdio_out;
   logic        sdio_oe;
   logic        is_read;
   logic        stream;
   logic        apb_go;
   logic        start;
   logic [5:0]  next_idx;
   logic [2:0]  nbytes;

   function automatic logic [7:0] rev8(input logic [7:0] b);
      logic [7:0] r;
      for (int i = 0; i < 8; i++)
         r[i] = b[7 - i];
      return r;
   endfunction

   assign apb_go   = psel & penable & pready;
   assign start    = apb_go & pwrite & (paddr == scp_pkg::HREG_CTRL) &
                     pwdata[scp_pkg::CTRL_START_BIT] & (state == SCH_IDLE);
   assign next_idx = 6'(bit_idx + 6'h01);
   assign nbytes   = (instr[scp_pkg::LEN_MSB:scp_pkg::LEN_LSB] ==
                      scp_pkg::LEN_STREAM) ? 3'(scp_pkg::STREAM_BYTES) :
                     3'({1'b0, instr[scp_pkg::LEN_MSB:scp_pkg::LEN_LSB]}
                        + 3'h1);

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         ctrl    <= 4'h0;
         instr   <= 16'h6000;
         wdata   <= 32'h0000_0000;
      end
      else
      begin
         pready  <= psel & ~penable & ~pready;
         pslverr <= psel & ~penable & ~pready &
                    !(paddr inside {scp_pkg::HREG_CTRL, scp_pkg::HREG_INSTR,
                      scp_pkg::HREG_WDATA, scp_pkg::HREG_RDATA,
                      scp_pkg::HREG_STATUS});
         case (paddr)
            scp_pkg::HREG_CTRL:   prdata <= {28'h0, ctrl[3:1], 1'b0};
            scp_pkg::HREG_INSTR:  prdata <= {16'h0, instr};
            scp_pkg::HREG_WDATA:  prdata <= wdata;
            scp_pkg::HREG_RDATA:  prdata <= rdata;
            scp_pkg::HREG_STATUS: prdata <= {31'h0, state != SCH_IDLE};
            default:              prdata <= 32'h0000_0000;
         endcase
         if (apb_go && pwrite && state == SCH_IDLE)
         begin
            if (paddr == scp_pkg::HREG_CTRL)
               ctrl <= pwdata[3:0];
            if (paddr == scp_pkg::HREG_INSTR)
               instr <= pwdata[15:0];
            if (paddr == scp_pkg::HREG_WDATA)
               wdata <= pwdata;
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
         in_sync <= 2'h0;
      else
         in_sync <= {in_sync[0], ctrl[scp_pkg::CTRL_UNIDIR_BIT] ?
                     link.separate_readback_pin : link.sdio};
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         state    <= SCH_IDLE;
         cs_n     <= 1'b1;
         sclk     <= 1'b0;
         sdio_out <= 1'b0;
         sdio_oe  <= 1'b0;
         tx       <= 48'h0;
         rx       <= 32'h0;
         rdata    <= 32'h0;
         bit_idx  <= 6'h00;
         nbits    <= 6'h00;
         div      <= 5'h00;
         is_read  <= 1'b0;
         stream   <= 1'b0;
      end
      else
      begin
         div <= 5'(div + 5'h01);
         case (state)
            SCH_IDLE:
               if (start)
               begin
                  if (pwdata[scp_pkg::CTRL_LSB_BIT])
                     tx <= {rev8(instr[7:0]), rev8(instr[15:8]),
                            rev8(wdata[7:0]), rev8(wdata[15:8]),
                            rev8(wdata[23:16]), rev8(wdata[31:24])};
                  else
                     tx <= {instr, wdata[7:0], wdata[15:8],
                            wdata[23:16], wdata[31:24]};
                  sdio_out <= pwdata[scp_pkg::CTRL_LSB_BIT] ?
                              instr[0] : instr[15];
                  nbits   <= 6'(scp_pkg::INSTR_BITS) + {nbytes, 3'h0};
                  is_read <= instr[scp_pkg::INSTR_RW_BIT];
                  stream  <= nbytes == 3'(scp_pkg::STREAM_BYTES);
                  bit_idx <= 6'h00;
                  rx      <= 32'h0;
                  cs_n    <= 1'b0;
                  sdio_oe <= 1'b1;
                  div     <= 5'h00;
                  state   <= SCH_LEAD;
               end
            SCH_LEAD:
               if (div == 5'(scp_pkg::SCLK_HALF - 1))
               begin
                  sclk  <= 1'b1;
                  div   <= 5'h00;
                  state <= SCH_SHIFT;
               end
            SCH_SHIFT:
               if (div == 5'(scp_pkg::SCLK_HALF - 1))
               begin
                  div <= 5'h00;
                  if (!sclk)
                     sclk <= 1'b1;
                  else
                  begin
                     sclk     <= 1'b0;
                     bit_idx  <= next_idx;
                     tx       <= {tx[46:0], 1'b0};
                     sdio_out <= tx[46];
                     sdio_oe  <= !is_read ||
                                 next_idx < 6'(scp_pkg::INSTR_BITS);
                     if (is_read && bit_idx >= 6'(scp_pkg::INSTR_BITS))
                        rx <= {rx[30:0], in_sync[1]};
                     if (next_idx == nbits)
                        state <= SCH_TAIL;
                     else if (ctrl[scp_pkg::CTRL_STALL_BIT] && !stream &&
                              next_idx[2:0] == 3'h0)
                     begin
                        cs_n  <= 1'b1;
                        state <= SCH_GAP;
                     end
                  end
               end
            SCH_GAP:
               if (div == 5'(scp_pkg::STALL_CYCLES - 1))
               begin
                  cs_n  <= 1'b0;
                  div   <= 5'h00;
                  state <= SCH_LEAD;
               end
            SCH_TAIL:
               if (div == 5'(scp_pkg::SCLK_HALF - 1))
               begin
                  cs_n    <= 1'b1;
                  sdio_oe <= 1'b0;
                  if (is_read)
                     rdata <= ctrl[scp_pkg::CTRL_LSB_BIT] ?
                              {rev8(rx[31:24]), rev8(rx[23:16]),
                               rev8(rx[15:8]), rev8(rx[7:0])} : rx;
                  state <= SCH_IDLE;
               end
            default:
               state <= SCH_IDLE;
         endcase
      end
   end

   assign link.cs_n          = cs_n;
   assign link.sclk          = sclk;
   assign link.host_sdio_out = sdio_out;
   assign link.host_sdio_oe  = sdio_oe;
endmodule

/* File: tb/scp_monitor.sv */
// Link checker for the serial configuration port.
// Assumes the bench hands it the link signals and the system clock.
`timescale 1ns/1ps
module scp_monitor (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Link
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic host_sdio_out,
   input wire logic host_sdio_oe,
   input wire logic dev_sdio_out,
   input wire logic dev_sdio_oe,
   input wire logic separate_readback_pin_oe
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   logic [2:0] rises;
   always_ff @(posedge clock)
   begin
      if (!reset_n)
         rises <= 3'h0;
      else if ($rose(sclk))
         rises <= rises + 3'h1;
   end
   oe_release_a: assert property (cs_n [*4] |->
      !dev_sdio_oe && !separate_readback_pin_oe) else $error("pin driven");
   select_lead_a: assert property ($fell(cs_n) |-> !sclk [*3])
      else $error("clock too soon");
   idle_clock_a: assert property (cs_n |-> !sclk)
      else $error("clock outside frame");
   dev_stable_a: assert property ($rose(sclk) && dev_sdio_oe |=>
      $stable(dev_sdio_out) [*3]) else $error("readback moved");
   host_stable_a: assert property ($rose(sclk) && host_sdio_oe |->
      $stable(host_sdio_out)) else $error("write data moved");
   no_fight_a: assert property (!(dev_sdio_oe && host_sdio_oe))
      else $error("both drive data");
   pin_pick_a: assert property (!(dev_sdio_oe &&
      separate_readback_pin_oe)) else $error("both pins driven");
   byte_bound_a: assert property ($rose(cs_n) |-> rises == 3'h0)
      else $error("select off boundary");
   in_frame_a: assert property ($rose(dev_sdio_oe) ||
      $rose(separate_readback_pin_oe) |-> !cs_n) else $error("drive idle");
   cover property ($rose(dev_sdio_oe));
   cover property ($rose(separate_readback_pin_oe));
   cover property ($rose(cs_n) ##[1:20] $fell(cs_n));
endmodule

/* File: tb/testbench.sv */
// Bench: controller end drives the port end; a byte model checks reads.
// Assumes both ends share one 40 MHz clock and reset.
`timescale 1ns/1ps
module testbench;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic [9:0]  user_addr = 10'h000;
   logic [7:0]  user_data;
   logic        unidir_mode;
   logic        lsb_first;
   logic        update_pulse;
   int          pulses = 0;
   logic [7:0]  bm [0:1023];
   logic [7:0]  am [0:1023];
   logic        rb_act = 1'b0;
   int          mismatches = 0;
   int          comparisons = 0;
   int          seed = 34346;
   logic [31:0] q;
   scp_if scp_if_i ();
   scp_device scp_device_i (.clock(clock), .reset_n(reset_n),
      .link(scp_if_i), .user_addr(user_addr), .user_data(user_data),
      .update_pulse(update_pulse), .unidir_mode(unidir_mode),
      .lsb_first(lsb_first));
   scp_host scp_host_i (.clock(clock), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(), .link(scp_if_i));
   scp_monitor scp_monitor_i (.clock(clock), .reset_n(reset_n),
      .cs_n(scp_if_i.cs_n), .sclk(scp_if_i.sclk),
      .host_sdio_out(scp_if_i.host_sdio_out),
      .host_sdio_oe(scp_if_i.host_sdio_oe),
      .dev_sdio_out(scp_if_i.dev_sdio_out),
      .dev_sdio_oe(scp_if_i.dev_sdio_oe),
      .separate_readback_pin_oe(scp_if_i.separate_readback_pin_oe));
   always #12.5 clock = ~clock;
   always @(posedge clock)
      if (update_pulse === 1'b1)
         pulses <= pulses + 1;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1)
         @(posedge clock);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Software must poll busy; a hung transfer counts as a mismatch.
   task automatic op(input logic rd, input logic [1:0] len,
                     input logic [9:0] a, input logic [31:0] wd,
                     input logic [2:0] ctl);
      int n;
      logic [31:0] r;
      apb(1'b1, scp_pkg::HREG_WDATA, wd);
      apb(1'b1, scp_pkg::HREG_INSTR, {16'h0, rd, len, 3'h0, a});
      apb(1'b1, scp_pkg::HREG_CTRL, {28'h0, ctl, 1'b1});
      n = 0;
      q = 32'h1;
      while (q[0] !== 1'b0 && n < 500)
      begin
         apb(1'b0, scp_pkg::HREG_STATUS, 32'h0);
         n++;
      end
      if (n == 500)
         mismatches++;
      apb(1'b0, scp_pkg::HREG_RDATA, 32'h0);
      r = 32'h0;
      for (int i = 0; i <= len; i++)
      begin
         if (rd)
            r = {r[23:0], rb_act ? am[a] : bm[a]};
         else
         begin
            bm[a] = wd[8*i +: 8];
            if (a == scp_pkg::ADDR_READBACK)
               rb_act = wd[8*i];
            if (a == scp_pkg::ADDR_UPDATE && wd[8*i])
            begin
               am = bm;
               bm[a] = 8'h00;
               am[a] = 8'h00;
            end
         end
         a = ctl[0] ? 10'(a + 10'h1) : 10'(a - 10'h1);
      end
      if (rd)
         chk(q & (32'hFFFF_FFFF >> (8 * (3 - len))), r);
   endtask
   task automatic uchk(input logic [9:0] a);
      @(posedge clock);
      user_addr <= a;
      repeat (2) @(posedge clock);
      chk({24'h0, user_data}, {24'h0, am[a]});
   endtask
   initial
   begin
      logic [31:0] d;
      repeat (6) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      chk({31'h0, unidir_mode}, 32'h0);
      for (int k = 0; k < 3; k++)
      begin
         d = $random(seed);
         op(1'b0, k[1:0], 10'h0A2, d, 3'h4);
         op(1'b1, k[1:0], 10'h0A2, 32'h0, 3'h4);
      end
      d = $random(seed);
      op(1'b0, 2'h3, 10'h0A3, d, 3'h0);
      op(1'b1, 2'h3, 10'h0A3, 32'h0, 3'h0);
      op(1'b0, 2'h0, scp_pkg::ADDR_UPDATE, 32'h1, 3'h0);
      chk(pulses, 32'h1);
      for (int k = 0; k < 4; k++)
         uchk(10'h0A0 + k[9:0]);
      op(1'b1, 2'h0, scp_pkg::ADDR_UPDATE, 32'h0, 3'h0);
      d = $random(seed);
      op(1'b0, 2'h0, 10'h0A1, d, 3'h0);
      uchk(10'h0A1);
      op(1'b0, 2'h0, scp_pkg::ADDR_READBACK, 32'h1, 3'h0);
      op(1'b1, 2'h2, 10'h0A2, 32'h0, 3'h0);
      op(1'b0, 2'h0, scp_pkg::ADDR_READBACK, 32'h0, 3'h0);
      op(1'b1, 2'h2, 10'h0A2, 32'h0, 3'h0);
      op(1'b0, 2'h0, scp_pkg::ADDR_PORT_CFG, 32'h99, 3'h0);
      chk({31'h0, unidir_mode}, 32'h1);
      op(1'b1, 2'h2, 10'h0A2, 32'h0, 3'h2);
      op(1'b0, 2'h0, scp_pkg::ADDR_PORT_CFG, 32'h18, 3'h2);
      chk({31'h0, unidir_mode}, 32'h0);
      op(1'b0, 2'h0, scp_pkg::ADDR_PORT_CFG, 32'h5A, 3'h0);
      chk({31'h0, lsb_first}, 32'h1);
      d = $random(seed);
      op(1'b0, 2'h2, 10'h0B0, d, 3'h5);
      op(1'b1, 2'h2, 10'h0B0, 32'h0, 3'h5);
      op(1'b0, 2'h0, scp_pkg::ADDR_PORT_CFG, 32'h18, 3'h1);
      chk({31'h0, lsb_first}, 32'h0);
      stop_test;
   end
   initial
   begin
      #1000000;
      mismatches++;
      stop_test;
   end
endmodule
